/* File: hw/tsh_map.svh */
// Constants for the temperature sensor bus host: timing, addresses, filter
`ifndef TSH_MAP_SVH
`define TSH_MAP_SVH

// System clock period and the quarter of one SCL period, both in ns
`define TSH_CLK_NS        8
`define TSH_SCL_QTR_NS    625
// Least time, so rounded up to whole cycles
`define TSH_SCL_QTR_CYC   ((`TSH_SCL_QTR_NS + `TSH_CLK_NS - 1) / `TSH_CLK_NS)

// Upper four address bits per function
`define TSH_TYPE_TEMP     4'h9
`define TSH_TYPE_EEPROM   4'ha
// SMBus alert response address, 7 bits
`define TSH_ARA_ADDR      7'h0c

// Byte and phase framing
`define TSH_LAST_BIT      3'h7
`define TSH_LAST_PH       2'h3
// Consecutive equal samples needed before a filtered input moves
`define TSH_FILT_LEN      3

`endif

/* File: hw/tsh_pkg.sv */
// Types of the temperature sensor bus host
package tsh_pkg;

    typedef enum logic [1:0] {
        TSH_CMD_ADDR = 2'h0,
        TSH_CMD_ARA  = 2'h1,
        TSH_CMD_WR   = 2'h2,
        TSH_CMD_RD   = 2'h3
    } tsh_cmd_t;

    typedef enum logic [2:0] {
        TSH_ST_IDLE  = 3'h0,
        TSH_ST_WAIT  = 3'h1,
        TSH_ST_START = 3'h2,
        TSH_ST_BIT   = 3'h3,
        TSH_ST_ACK   = 3'h4,
        TSH_ST_STOP  = 3'h5,
        TSH_ST_DONE  = 3'h6
    } tsh_state_t;

endpackage

/* File: hw/tsh_if.sv */
// Carrier between the bus host and its tick generator and input filter
`timescale 1ns/1ps
`default_nettype none

interface tsh_if;
    logic       tick;
    logic [2:0] raw;
    logic [2:0] clean;

    modport gen (output tick);
    modport syn (input raw, output clean);
    modport use_side (input tick, input clean, output raw);
endinterface

`default_nettype wire

/* File: hw/tsh_sync.sv */
// Two-flop synchroniser and spike filter for SCL, SDA and alarm pins
`timescale 1ns/1ps
`default_nettype none
`include "tsh_map.svh"

module tsh_sync (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    tsh_if.syn        bus
);
    logic [2:0] meta;
    logic [2:0] sync;
    logic [2:0] hist [`TSH_FILT_LEN];

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= 3'h7;
            sync <= 3'h7;
        end else begin
            meta <= bus.raw;
            sync <= meta;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < `TSH_FILT_LEN; k++) begin
                hist[k] <= 3'h7;
            end
        end else begin
            hist[0] <= sync;
            for (int k = 1; k < `TSH_FILT_LEN; k++) begin
                hist[k] <= hist[k-1];
            end
        end
    end

    // A level moves only after it has stood for the whole history
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.clean <= 3'h7;
        end else begin
            for (int b = 0; b < 3; b++) begin
                if (hist[0][b] == hist[1][b] && hist[1][b] == hist[2][b]) begin
                    bus.clean[b] <= hist[0][b];
                end
            end
        end
    end
endmodule

`default_nettype wire

/* File: hw/tsh_sclgen.sv */
// Free-running quarter-period tick for SCL generation
`timescale 1ns/1ps
`default_nettype none
`include "tsh_map.svh"

module tsh_sclgen (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    tsh_if.gen        bus
);
    localparam logic [6:0] QTR_LAST = 7'(`TSH_SCL_QTR_CYC - 1);

    logic [6:0] cnt;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt      <= 7'h00;
            bus.tick <= 1'b0;
        end else begin
            bus.tick <= (cnt == QTR_LAST);
            cnt      <= (cnt == QTR_LAST) ? 7'h00 : cnt + 7'h01;
        end
    end
endmodule

`default_nettype wire

/* File: hw/tsh_host.sv */
// Bus host that drives the temperature sensor over SCL and SDA
`timescale 1ns/1ps
`default_nettype none
`include "tsh_map.svh"

// How it works
// - Host expects active-low alarms when several devices share the alert line.
// - Host can send the SMBus alert response address to find the alerting device.
// - Host is the only master; it starts and clocks every transfer.
// - Each byte goes most significant bit first, one bit per clock.
// - Each byte takes nine clocks, the ninth for acknowledge.
// - Host clocks each byte and its acknowledge with no gaps or spare clocks; SCL stays low between commands until a Stop, which leaves it released.
// - SDA changes only with SCL low, except for Start and Stop.
// - Any number of bytes between Start and Stop, chosen by the host.
// - Bus is idle only when SCL and SDA are both high.
// - A repeated Start may replace Stop and begins a new transfer.
// - Host releases SDA during the ninth clock after each written byte.
// - Host leaves SDA high on the last read byte to end the read.
// - Last address bit is one for read, zero for write.
module tsh_host (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_cmd_valid,
    input  wire logic [1:0] i_cmd_kind,
    input  wire logic       i_cmd_start,
    input  wire logic       i_cmd_stop,
    input  wire logic       i_cmd_rw,
    input  wire logic       i_cmd_last,
    input  wire logic       i_cmd_eeprom,
    input  wire logic [2:0] i_addr_select_pins,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_alarm_polarity,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_alarm_n_pin,
    output logic            o_cmd_ready,
    output logic            o_done,
    output logic [7:0]      o_rdata,
    output logic            o_nack,
    output logic            o_bus_held,
    output logic            o_alarm,
    output logic            o_scl_o,
    output logic            o_scl_oe,
    output logic            o_sda_o,
    output logic            o_sda_oe
);
    localparam int SCL_LOW_MAX = 2 * `TSH_SCL_QTR_CYC + 2;

    tsh_if link ();

    tsh_sclgen u_gen (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .bus       (link)
    );

    tsh_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .bus       (link)
    );

    assign link.raw = {i_alarm_n_pin, i_sda, i_scl};

    // Address byte: type nibble, pin bits, direction
    function automatic logic [7:0] addr_byte(input logic eeprom,
                                             input logic [2:0] pins,
                                             input logic rw);
        logic [3:0] kind;
        kind = eeprom ? `TSH_TYPE_EEPROM : `TSH_TYPE_TEMP;
        return {kind, pins, rw};
    endfunction

    tsh_pkg::tsh_state_t st;
    logic [1:0]          ph;
    logic [2:0]          bitcnt;
    logic [7:0]          shreg;
    logic                rd_q;
    logic                last_q;
    logic                stop_q;
    logic                scl_in;
    logic                sda_in;
    logic                bus_idle;
    logic                tick;

    assign scl_in   = link.clean[0];
    assign sda_in   = link.clean[1];
    assign tick     = link.tick;
    assign bus_idle = scl_in && sda_in;

    // Open-drain pins only ever pull low
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_scl_o <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            o_scl_o <= 1'b0;
            o_sda_o <= 1'b0;
        end
    end

    // Phase within one SCL period advances on each quarter tick outside IDLE and WAIT, where it is held at zero
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph <= 2'h0;
        end else if (st == tsh_pkg::TSH_ST_IDLE || st == tsh_pkg::TSH_ST_WAIT) begin
            ph <= 2'h0;
        end else if (tick) begin
            ph <= ph + 2'h1;
        end
    end

    // Main sequencer
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= tsh_pkg::TSH_ST_IDLE;
        end else begin
            unique case (st)
                tsh_pkg::TSH_ST_IDLE: begin
                    if (i_cmd_valid && o_cmd_ready) begin
                        if (!i_cmd_start) begin
                            st <= tsh_pkg::TSH_ST_BIT;
                        end else if (o_bus_held) begin
                            st <= tsh_pkg::TSH_ST_START;
                        end else begin
                            st <= tsh_pkg::TSH_ST_WAIT;
                        end
                    end
                end
                tsh_pkg::TSH_ST_WAIT: begin
                    // Only start on a bus nobody else holds
                    if (bus_idle && tick) begin
                        st <= tsh_pkg::TSH_ST_START;
                    end
                end
                tsh_pkg::TSH_ST_START: begin
                    if (tick && ph == `TSH_LAST_PH) begin
                        st <= tsh_pkg::TSH_ST_BIT;
                    end
                end
                tsh_pkg::TSH_ST_BIT: begin
                    if (tick && ph == `TSH_LAST_PH && bitcnt == `TSH_LAST_BIT) begin
                        st <= tsh_pkg::TSH_ST_ACK;
                    end
                end
                tsh_pkg::TSH_ST_ACK: begin
                    if (tick && ph == `TSH_LAST_PH) begin
                        st <= stop_q ? tsh_pkg::TSH_ST_STOP : tsh_pkg::TSH_ST_DONE;
                    end
                end
                tsh_pkg::TSH_ST_STOP: begin
                    if (tick && ph == `TSH_LAST_PH) begin
                        st <= tsh_pkg::TSH_ST_DONE;
                    end
                end
                tsh_pkg::TSH_ST_DONE: begin
                    st <= tsh_pkg::TSH_ST_IDLE;
                end
                default: begin
                    st <= tsh_pkg::TSH_ST_IDLE;
                end
            endcase
        end
    end

    // Command capture
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_q   <= 1'b0;
            last_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (st == tsh_pkg::TSH_ST_IDLE && i_cmd_valid && o_cmd_ready) begin
            rd_q   <= (i_cmd_kind == tsh_pkg::TSH_CMD_RD);
            last_q <= i_cmd_last;
            stop_q <= i_cmd_stop;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cmd_ready <= 1'b0;
        end else begin
            o_cmd_ready <= (st == tsh_pkg::TSH_ST_IDLE) && !(i_cmd_valid && o_cmd_ready);
        end
    end

    // Shift register: loaded per command, shifted after each sample
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shreg <= 8'hff;
        end else if (st == tsh_pkg::TSH_ST_IDLE && i_cmd_valid && o_cmd_ready) begin
            unique case (tsh_pkg::tsh_cmd_t'(i_cmd_kind))
                tsh_pkg::TSH_CMD_ADDR: shreg <= addr_byte(i_cmd_eeprom, i_addr_select_pins,
                                                          i_cmd_rw);
                tsh_pkg::TSH_CMD_ARA:  shreg <= {`TSH_ARA_ADDR, 1'b1};
                tsh_pkg::TSH_CMD_WR:   shreg <= i_wdata;
                tsh_pkg::TSH_CMD_RD:   shreg <= 8'hff;
            endcase
        end else if (st == tsh_pkg::TSH_ST_BIT && tick && ph == 2'h2) begin
            shreg <= {shreg[6:0], sda_in};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bitcnt <= 3'h0;
        end else if (st != tsh_pkg::TSH_ST_BIT) begin
            bitcnt <= 3'h0;
        end else if (tick && ph == `TSH_LAST_PH) begin
            bitcnt <= bitcnt + 3'h1;
        end
    end

    // SCL: released in phase 1, pulled low in phase 3
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_scl_oe <= 1'b0;
        end else if (tick && st != tsh_pkg::TSH_ST_IDLE && st != tsh_pkg::TSH_ST_WAIT
                     && st != tsh_pkg::TSH_ST_DONE) begin
            if (ph == 2'h1) begin
                o_scl_oe <= 1'b0;
            end else if (ph == `TSH_LAST_PH && st != tsh_pkg::TSH_ST_STOP) begin
                o_scl_oe <= 1'b1;
            end
        end
    end

    // SDA: data changes in phase 0 with SCL low; Start and Stop use phase 2
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda_oe <= 1'b0;
        end else if (tick) begin
            unique case (st)
                tsh_pkg::TSH_ST_START: begin
                    if (ph == 2'h0) begin
                        o_sda_oe <= 1'b0;
                    end else if (ph == 2'h2) begin
                        o_sda_oe <= 1'b1;
                    end
                end
                tsh_pkg::TSH_ST_BIT: begin
                    if (ph == 2'h0) begin
                        o_sda_oe <= rd_q ? 1'b0 : !shreg[7];
                    end
                end
                tsh_pkg::TSH_ST_ACK: begin
                    if (ph == 2'h0) begin
                        // Reading: drive ACK unless this is the last byte
                        o_sda_oe <= rd_q && !last_q;
                    end
                end
                tsh_pkg::TSH_ST_STOP: begin
                    if (ph == 2'h0) begin
                        o_sda_oe <= 1'b1;
                    end else if (ph == 2'h2) begin
                        o_sda_oe <= 1'b0;
                    end
                end
                default: begin
                    o_sda_oe <= o_sda_oe;
                end
            endcase
        end
    end

    // Acknowledge seen from the device on written bytes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_nack <= 1'b0;
        end else if (st == tsh_pkg::TSH_ST_ACK && tick && ph == 2'h2) begin
            o_nack <= rd_q ? 1'b0 : sda_in;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done  <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            o_done <= (st == tsh_pkg::TSH_ST_DONE);
            if (st == tsh_pkg::TSH_ST_DONE) begin
                o_rdata <= shreg;
            end
        end
    end

    // Bus ownership from Start until Stop completes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_held <= 1'b0;
        end else if (st == tsh_pkg::TSH_ST_START) begin
            o_bus_held <= 1'b1;
        end else if (st == tsh_pkg::TSH_ST_STOP && tick && ph == `TSH_LAST_PH) begin
            o_bus_held <= 1'b0;
        end
    end

    // Shared alert lines are wire-ANDed, so active low is the safe default
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alarm <= 1'b0;
        end else begin
            o_alarm <= i_alarm_polarity ? link.clean[2] : !link.clean[2];
        end
    end

    // Helper: length of each SCL low stretch inside a byte
    logic [8:0] low_cnt;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt <= 9'h000;
        end else if (o_scl_oe && (st == tsh_pkg::TSH_ST_BIT || st == tsh_pkg::TSH_ST_ACK)) begin
            low_cnt <= low_cnt + 9'h001;
        end else begin
            low_cnt <= 9'h000;
        end
    end

    AST_SDA_ONLY_SCL_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($changed(o_sda_oe) && !o_scl_oe && !$past(o_scl_oe))
        |-> ($past(st) == tsh_pkg::TSH_ST_START || $past(st) == tsh_pkg::TSH_ST_STOP))
        else $error("SDA moved while SCL high outside Start or Stop");

    AST_DATA_AFTER_FALL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($changed(o_sda_oe) && $past(st) == tsh_pkg::TSH_ST_BIT) |-> $past(o_scl_oe))
        else $error("Data bit changed while SCL released");

    AST_MSB_FIRST: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (st == tsh_pkg::TSH_ST_BIT && !rd_q && ph == 2'h1 && bitcnt == 3'h0)
        |-> (o_sda_oe == !shreg[7]))
        else $error("First bit is not the top bit of the byte");

    AST_NINE_CLOCKS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(st == tsh_pkg::TSH_ST_ACK) |-> ($past(bitcnt) == `TSH_LAST_BIT))
        else $error("Acknowledge clock not after eight data bits");

    AST_NO_GAPS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        low_cnt <= 9'(SCL_LOW_MAX))
        else $error("SCL held low too long inside a byte");

    AST_IDLE_BEFORE_START: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($past(st) == tsh_pkg::TSH_ST_WAIT && st == tsh_pkg::TSH_ST_START) |-> $past(bus_idle))
        else $error("Start issued on a busy bus");

    AST_RELEASE_ON_ACK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (st == tsh_pkg::TSH_ST_ACK && !rd_q && ph != 2'h0) |-> !o_sda_oe)
        else $error("Host drove SDA in the acknowledge of a written byte");

    AST_NACK_LAST_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (st == tsh_pkg::TSH_ST_ACK && rd_q && last_q && !o_scl_oe) |-> !o_sda_oe)
        else $error("Host acknowledged the last read byte");

    AST_REPEATED_START: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($rose(st == tsh_pkg::TSH_ST_START) && $past(o_bus_held)) |-> o_scl_oe [*2])
        else $error("Repeated Start began with SCL released");

    AST_ALARM_POLARITY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ##1 (o_alarm == ($past(i_alarm_polarity) ? $past(link.clean[2]) : !$past(link.clean[2]))))
        else $error("Alarm level ignores polarity");

    COV_READ_DONE:  cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_done && rd_q);
    COV_WRITE_NACK: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_done && !rd_q && o_nack);
    COV_REP_START:  cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(st == tsh_pkg::TSH_ST_START) && o_bus_held);
    COV_STOP:       cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(o_bus_held));
endmodule

`default_nettype wire

/* File: dv/tsh_dev.sv */
// Behavioural sensor device on the two-wire bus, seen from the host side
`timescale 1ns/1ps
`default_nettype none

module tsh_dev (
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [2:0] i_addr_select_pins,
    input  wire logic       i_alarm_polarity,
    input  wire logic       i_alarm_mode_select,
    input  wire logic       i_hot,
    output logic            o_sda_oe,
    output logic            o_alert_oe
);
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic [2:0] pins;
    logic       act = 0, rd = 0, adr = 0, pph = 0, ara = 0, ok = 0, alarm = 0;
    int         n = 0;

    initial o_sda_oe = 0;
    // Floating pins read as zero
    always_comb foreach (pins[i]) pins[i] = (i_addr_select_pins[i] === 1'b1);
    // Interrupt mode holds the alarm until an alert response clears it
    always @(i_hot) if (!i_alarm_mode_select || i_hot) alarm = i_hot;
    assign o_alert_oe = alarm ^ i_alarm_polarity;

    always @(negedge i_sda) if (i_scl === 1'b1) begin
        {act, adr, rd, pph, ara} = 5'h18;
        n = 0;
    end
    always @(posedge i_sda) if (i_scl === 1'b1) begin
        act = 0;
        o_sda_oe = 0;
    end
    always @(posedge i_scl) if (act) begin
        if (n < 8) sh = {sh[6:0], i_sda};
        else if (rd && i_sda) act = 0;
        n++;
    end
    // Drive changes only after SCL falls, so SDA is steady while SCL is high
    always @(negedge i_scl) if (act) begin
        if (n == 8 && !rd) begin
            if (adr) begin
                ara = sh[7:1] == 7'h0c;
                ok = sh[7:1] == {4'h9, pins} || sh[7:1] == {4'ha, pins} || ara && sh[0] && alarm;
            end else if (pph) begin
                ok = 1;
                ptr = sh;
            end else ok = ptr != 8'h00;
            o_sda_oe = ok;
        end else if (n == 8) o_sda_oe = 0;
        else if (n == 9) begin
            n = 0;
            if (adr) begin
                adr = 0;
                rd = sh[0];
                pph = !sh[0] && !ara;
                act = ok;
                if (ara && ok && i_alarm_mode_select) alarm = 0;
            end else pph = 0;
            if (rd && act) tx = ara ? {4'h9, pins, 1'h0} : ptr ^ 8'ha5;
            if (rd && act && !ara) ptr = ptr + 8'h01;
            o_sda_oe = rd && act && !tx[7];
        end else if (rd) o_sda_oe = !tx[7 - n];
    end
endmodule

`default_nettype wire

/* File: dv/tsh_host_tb.sv */
// Self-checking bench: bus host against the behavioural sensor device
`timescale 1ns/1ps
`default_nettype none

module tsh_host_tb;
    logic       clk = 0, rst_n = 0, valid = 0, st = 0, sp = 0, rw = 0, last = 0, ee = 0;
    logic       alarm_polarity = 0, hot = 0, mode = 0, spike = 0;
    logic [1:0] kind = 0;
    logic [2:0] pins = 0, dpins = 0;
    logic [7:0] wd = 0, ptr, rdata;
    logic [7:0] exp_q [$];
    logic [31:0] x, seed = 32'h00007191;
    logic       ready, done, nack, held, alarm, scl_o, scl_oe, sda_o, sda_oe, d_oe, al_oe;
    wire        scl = !scl_oe;
    wire        sda = !(sda_oe || d_oe);
    int         bad_count = 0, checked = 0;

    always #4 clk = !clk;

    tsh_host DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(valid), .i_cmd_kind(kind),
        .i_cmd_start(st), .i_cmd_stop(sp), .i_cmd_rw(rw), .i_cmd_last(last),
        .i_cmd_eeprom(ee), .i_addr_select_pins(pins), .i_wdata(wd), .i_alarm_polarity(alarm_polarity),
        .i_scl(scl), .i_sda(sda), .i_alarm_n_pin(!(al_oe || spike)), .o_cmd_ready(ready),
        .o_done(done), .o_rdata(rdata), .o_nack(nack), .o_bus_held(held), .o_alarm(alarm),
        .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe));
    tsh_dev u_dev (.i_scl(scl), .i_sda(sda), .i_addr_select_pins(dpins),
        .i_alarm_polarity(alarm_polarity), .i_alarm_mode_select(mode), .i_hot(hot),
        .o_sda_oe(d_oe), .o_alert_oe(al_oe));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] adr(input logic e, r);
        return {e ? 4'ha : 4'h9, pins, r};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One command, held until taken; then the acknowledge and echoed byte are compared
    task automatic cmd(input logic [1:0] k, input logic s, p, r, l, input logic [7:0] w,
                       input logic en, input logic [7:0] ed);
        int t;
        @(posedge clk);
        #1;
        {valid, kind, st, sp, rw, last} = {1'h1, k, s, p, r, l};
        wd = w;
        for (t = 0; ready !== 1'b1 && t < 200; t++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        valid = 0;
        for (t = 0; done !== 1'b1 && t < 6000; t++) begin
            @(posedge clk);
            #1;
        end
        check("done", done, 1);
        check("nack", nack, en);
        check("byte", rdata, ed);
        check("held", held, !p);
    endtask

    initial begin
        #(95000 * 8);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1;
        check("ready in reset", ready, 0);
        check("pins in reset", {scl_oe, sda_oe, scl_o, sda_o}, 0);
        rst_n = 1;
        x = rnd();
        dpins = x[2:0];
        pins = dpins;
        ptr = x[15:8] | 8'h01;
        // Device model: a read at the pointer returns it xor a5, then the pointer steps
        exp_q.push_back(ptr ^ 8'ha5);
        exp_q.push_back((ptr + 8'h01) ^ 8'ha5);
        cmd(0, 1, 0, 0, 0, 0, 0, adr(0, 0));
        cmd(2, 0, 0, 0, 0, ptr, 0, ptr);
        cmd(2, 0, 1, 0, 0, x[23:16], 0, x[23:16]);
        $display("test write done");
        cmd(0, 1, 0, 0, 0, 0, 0, adr(0, 0));
        cmd(2, 0, 0, 0, 0, ptr, 0, ptr);
        cmd(0, 1, 0, 1, 0, 0, 0, adr(0, 1));
        cmd(3, 0, 0, 0, 0, 0, 0, exp_q.pop_front());
        cmd(3, 0, 1, 0, 1, 0, 0, exp_q.pop_front());
        $display("test repeated start read done");
        cmd(0, 1, 0, 0, 0, 0, 0, adr(0, 0));
        cmd(2, 0, 0, 0, 0, 8'h00, 0, 8'h00);
        cmd(2, 0, 1, 0, 0, x[31:24], 1, x[31:24]);
        $display("test refused write done");
        ee = 1;
        cmd(0, 1, 1, 0, 0, 0, 0, adr(1, 0));
        ee = 0;
        pins = dpins ^ 3'h4;
        cmd(0, 1, 1, 0, 0, 0, 1, adr(0, 0));
        pins = dpins;
        $display("test addressing done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            {alarm_polarity, hot} = i[1:0];
            repeat (20) @(posedge clk);
            #1;
            check("alarm", alarm, hot);
        end
        // A two-sample dip on the alarm pin must not reach the output
        spike = 1;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1;
            spike = (i == 0);
            check("alarm spike", alarm, 1);
        end
        alarm_polarity = 0;
        mode = 1;
        hot = 0;
        repeat (20) @(posedge clk);
        #1;
        check("alarm held", alarm, 1);
        $display("test alarm done");
        cmd(1, 1, 0, 1, 0, 0, 0, 8'h19);
        cmd(3, 0, 1, 0, 1, 0, 0, adr(0, 0));
        check("alarm cleared", alarm, 0);
        cmd(1, 1, 1, 1, 0, 0, 1, 8'h19);
        $display("test alert response done");
        close_out();
    end
endmodule

`default_nettype wire
